// >>> lock_window_detector.sv
`timescale 1ns/1ps
`default_nettype none
module lock_window_detector
   import pll_pwr_pkg::*;
#(
   parameter int ERR_W    = LD_ERR_W,
   parameter int ENTER_NS = LD_MAIN_ENTER_NS,
   parameter int EXIT_NS  = LD_MAIN_EXIT_NS,
   parameter int COUNT    = LD_COUNT
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // reference cycle and measured phase error
   input  wire logic             ref_tick,
   input  wire logic [ERR_W-1:0] phase_err_ns,
   input  wire logic             power_down,
   // result
   output logic                  locked
);
   localparam int CW = $clog2(COUNT + 1);
   localparam logic [ERR_W-1:0] ENTER = ERR_W'(ENTER_NS);
   localparam logic [ERR_W-1:0] EXIT  = ERR_W'(EXIT_NS);
   localparam logic [CW-1:0]    LAST  = CW'(COUNT - 1);

   logic [CW-1:0] good_cnt_reg;
   logic [CW-1:0] good_cnt_next;
   logic          lock_reg;
   logic          lock_next;
   wire           err_inside  = phase_err_ns < ENTER;
   wire           err_outside = phase_err_ns > EXIT;

   // ------------------------------------------------------------
   // window hysteresis: narrow to enter, wide to leave
   // ------------------------------------------------------------
   always_comb begin
      good_cnt_next = good_cnt_reg;
      lock_next     = lock_reg;
      if (power_down) begin
         good_cnt_next = '0;
         lock_next     = 1'b0;
      end else if (ref_tick) begin
         if (lock_reg) begin
            if (err_outside) begin
               lock_next = 1'b0;
            end
            good_cnt_next = '0;
         end else if (err_inside) begin
            if (good_cnt_reg == LAST) begin
               lock_next     = 1'b1;
               good_cnt_next = '0;
            end else begin
               good_cnt_next = good_cnt_reg + CW'(1);
            end
         end else begin
            good_cnt_next = '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         good_cnt_reg <= '0;
         lock_reg     <= 1'b0;
      end else begin
         good_cnt_reg <= good_cnt_next;
         lock_reg     <= lock_next;
      end
   end

   assign locked = lock_reg;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence last_good_s;
      ref_tick && !power_down && err_inside && good_cnt_reg == LAST;
   endsequence

   enter_count_a: assert property (
      $rose(lock_reg) |-> $past(good_cnt_reg) == LAST
   ) else $error("lock rose without full run of good cycles");
   enter_step_a: assert property (
      !lock_reg ##0 last_good_s |=> lock_reg
   ) else $error("lock not taken after last good cycle");
   exit_wide_a: assert property (
      lock_reg && ref_tick && !power_down && !err_outside |=> lock_reg
   ) else $error("lock dropped inside wide window");
   exit_drop_a: assert property (
      lock_reg && ref_tick && err_outside |=> !lock_reg
   ) else $error("lock held past wide window");
endmodule
`default_nettype wire

// >>> loop_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// analog loop stand-in: reference ticks, phase error, pump tail
// ---------------------------------------------------------------
module loop_model #(
   parameter int HOLD = 4
) (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // bench control
   input  wire logic       run,
   input  wire logic [7:0] err_set,
   input  wire logic       stuck,
   // loop side
   input  wire logic       pump_on,
   output logic            tick,
   output logic [7:0]      err,
   output logic            busy
);
   logic [7:0] err_reg;
   int         tail_reg;
   // at most one tick per pclk keeps comparison at 10 MHz, below 20 MHz
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick     <= 1'b0;
         err_reg  <= 8'h00;
         tail_reg <= 0;
      end else begin
         tick    <= run;
         err_reg <= err_set;
         if (pump_on)
            tail_reg <= HOLD;
         else if (tail_reg != 0 && !stuck)
            tail_reg <= tail_reg - 1;
      end
   end
   // error is meaningful only with a tick, so it scrambles in between
   assign err  = tick ? err_reg : ~err_reg;
   assign busy = pump_on | (tail_reg != 0);
endmodule
`default_nettype wire

// >>> pll_power_and_lock_detect.sv
`timescale 1ns/1ps
`default_nettype none
module pll_power_and_lock_detect
   import pll_pwr_pkg::*;
#(
   parameter int ERR_W = LD_ERR_W,
   parameter int FBW   = FB_W
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   // chip enable pin
   input  wire logic             en_pin,
   // main loop analog side
   input  wire logic             main_ref_tick,
   input  wire logic [ERR_W-1:0] main_phase_err_ns,
   input  wire logic             main_pump_busy,
   output logic                  main_loop_powered,
   output logic                  main_pump_active,
   // aux loop analog side
   input  wire logic             aux_ref_tick,
   input  wire logic [ERR_W-1:0] aux_phase_err_ns,
   output logic                  aux_loop_powered,
   // lock pin and interrupt
   output logic                  lock_out,
   output logic                  irq
);
   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire setup_ph  = psel && !penable;
   wire access_ph = psel && penable;
   wire hit_ctrl  = paddr == CTRL_OFS;
   wire hit_fb    = paddr == FEEDBACK_OFS;
   wire hit_stat  = paddr == STATUS_OFS;
   wire hit_ist   = paddr == IRQ_STAT_OFS;
   wire hit_iclr  = paddr == IRQ_CLR_OFS;
   wire hit_ien   = paddr == IRQ_EN_OFS;
   wire mapped    = hit_ctrl || hit_fb || hit_stat
                 || hit_ist || hit_iclr || hit_ien;
   wire wr_acc    = access_ph && pwrite;
   wire ctrl_wr   = wr_acc && hit_ctrl;
   wire fb_wr     = wr_acc && hit_fb;
   wire iclr_wr   = wr_acc && hit_iclr;
   wire ien_wr    = wr_acc && hit_ien;

   assign pready  = 1'b1;
   assign pslverr = access_ph && !mapped;

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   logic [31:0]      ctrl_reg;
   logic [FBW-1:0]   feedback_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_stat_next;
   logic [IRQ_W-1:0] irq_en_reg;
   logic             wake_reg;
   logic             wake_next;

   wire main_loop_sleep_bit = ctrl_reg[CTRL_MAIN_SLEEP];
   wire aux_loop_sleep_bit  = ctrl_reg[CTRL_AUX_SLEEP];
   wire main_pump_hiz_bit   = ctrl_reg[CTRL_MAIN_HIZ];
   wire [CTRL_WAKE_W-1:0] main_auto_wake_field =
      ctrl_reg[CTRL_WAKE_LSB +: CTRL_WAKE_W];
   wire [CTRL_SEL_W-1:0] output_select_field =
      ctrl_reg[CTRL_SEL_LSB +: CTRL_SEL_W];
   wire wake_on = main_auto_wake_field != '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg     <= CTRL_RESET;
         feedback_reg <= '0;
         irq_en_reg   <= '0;
      end else begin
         if (ctrl_wr) begin
            ctrl_reg <= pwdata & CTRL_WR_MASK;
         end
         if (fb_wr) begin
            feedback_reg <= pwdata[FBW-1:0];
         end
         if (ien_wr) begin
            irq_en_reg <= pwdata[IRQ_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // auto-wake latch
   // ------------------------------------------------------------
   // held until software rewrites control, so a later sleep
   // request is honoured; the pin always wins
   always_comb begin
      wake_next = wake_reg;
      if (!en_pin) begin
         wake_next = 1'b0;
      end else if (fb_wr && wake_on) begin
         wake_next = 1'b1;
      end else if (ctrl_wr) begin
         wake_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= wake_next;
      end
   end

   // ------------------------------------------------------------
   // main loop power state
   // ------------------------------------------------------------
   loop_state_e main_state_reg;
   loop_state_e main_state_next;

   always_comb begin
      main_state_next = main_state_reg;
      if (!en_pin) begin
         main_state_next = ST_ASYNC_DOWN;
      end else if (wake_reg) begin
         main_state_next = ST_ACTIVE;
      end else if (!main_loop_sleep_bit) begin
         main_state_next = main_pump_hiz_bit ? ST_HIZ
                                             : ST_ACTIVE;
      end else if (main_pump_hiz_bit) begin
         main_state_next = ST_ASYNC_DOWN;
      end else begin
         // a pump stuck on stalls here; hiz bit forces the way out
         case (main_state_reg)
            ST_SYNC_DOWN: begin
               main_state_next = ST_SYNC_DOWN;
            end
            ST_ASYNC_DOWN: begin
               main_state_next = ST_SYNC_DOWN;
            end
            default: begin
               main_state_next = main_pump_busy ? ST_SYNC_WAIT
                                                : ST_SYNC_DOWN;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_state_reg <= ST_ASYNC_DOWN;
      end else begin
         main_state_reg <= main_state_next;
      end
   end

   wire main_down = main_state_reg == ST_SYNC_DOWN
                 || main_state_reg == ST_ASYNC_DOWN;
   assign main_loop_powered = !main_down;
   assign main_pump_active  = main_state_reg == ST_ACTIVE;

   // ------------------------------------------------------------
   // aux loop power state
   // ------------------------------------------------------------
   logic aux_up_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_up_reg <= 1'b0;
      end else begin
         aux_up_reg <= en_pin && !aux_loop_sleep_bit;
      end
   end

   assign aux_loop_powered = aux_up_reg;

   // ------------------------------------------------------------
   // lock detectors
   // ------------------------------------------------------------
   logic main_lock;
   logic aux_lock;

   lock_window_detector #(
      .ERR_W    (ERR_W),
      .ENTER_NS (LD_MAIN_ENTER_NS),
      .EXIT_NS  (LD_MAIN_EXIT_NS),
      .COUNT    (LD_COUNT)
   ) u_main_ld (
      .pclk         (pclk),
      .presetn      (presetn),
      .ref_tick     (main_ref_tick),
      .phase_err_ns (main_phase_err_ns),
      .power_down   (main_down),
      .locked       (main_lock)
   );

   lock_window_detector #(
      .ERR_W    (ERR_W),
      .ENTER_NS (LD_AUX_ENTER_NS),
      .EXIT_NS  (LD_AUX_EXIT_NS),
      .COUNT    (LD_COUNT)
   ) u_aux_ld (
      .pclk         (pclk),
      .presetn      (presetn),
      .ref_tick     (aux_ref_tick),
      .phase_err_ns (aux_phase_err_ns),
      .power_down   (!aux_up_reg),
      .locked       (aux_lock)
   );

   // ------------------------------------------------------------
   // lock pin select
   // ------------------------------------------------------------
   logic lock_out_reg;
   logic lock_sel;

   always_comb begin
      case (output_select_field)
         SEL_MAIN:     lock_sel = main_lock;
         SEL_AUX:      lock_sel = aux_lock;
         SEL_COMBINED: lock_sel = main_lock && aux_lock;
         default:      lock_sel = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_out_reg <= 1'b0;
      end else begin
         lock_out_reg <= lock_sel;
      end
   end

   assign lock_out = lock_out_reg;

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   logic main_lock_d;
   logic aux_lock_d;
   wire [IRQ_W-1:0] events = {
      aux_lock_d && !aux_lock,
      !aux_lock_d && aux_lock,
      main_lock_d && !main_lock,
      !main_lock_d && main_lock
   };
   wire [IRQ_W-1:0] clr_mask = iclr_wr ? pwdata[IRQ_W-1:0] : '0;

   // set wins over a clear in the same cycle
   assign irq_stat_next = (irq_stat_reg & ~clr_mask) | events;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= '0;
         main_lock_d  <= 1'b0;
         aux_lock_d   <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         main_lock_d  <= main_lock;
         aux_lock_d   <= aux_lock;
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);

   // ------------------------------------------------------------
   // read data, latched in the setup cycle
   // ------------------------------------------------------------
   logic [31:0] status_word;
   logic [31:0] rd_mux;

   always_comb begin
      status_word               = '0;
      status_word[ST_MAIN_UP]   = main_loop_powered;
      status_word[ST_MAIN_PUMP] = main_pump_active;
      status_word[ST_MAIN_WAIT] = main_state_reg == ST_SYNC_WAIT;
      status_word[ST_AUX_UP]    = aux_up_reg;
      status_word[ST_MAIN_LOCK] = main_lock;
      status_word[ST_AUX_LOCK]  = aux_lock;
      status_word[ST_EN_PIN]    = en_pin;
      status_word[ST_WAKE]      = wake_reg;
   end

   always_comb begin
      rd_mux = '0;
      if (hit_ctrl) begin
         rd_mux = ctrl_reg;
      end else if (hit_fb) begin
         rd_mux = 32'(feedback_reg);
      end else if (hit_stat) begin
         rd_mux = status_word;
      end else if (hit_ist) begin
         rd_mux = 32'(irq_stat_reg);
      end else if (hit_ien) begin
         rd_mux = 32'(irq_en_reg);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup_ph && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence wake_write_s;
      fb_wr && en_pin && wake_on;
   endsequence
   sequence wake_kept_s;
      en_pin && !ctrl_wr;
   endsequence

   pin_low_down_a: assert property (
      !en_pin |=> main_state_reg == ST_ASYNC_DOWN && !aux_up_reg
   ) else $error("enable low did not force power down");
   both_awake_a: assert property (
      presetn && en_pin && !main_loop_sleep_bit && !aux_loop_sleep_bit
      |=> main_loop_powered && aux_loop_powered
   ) else $error("loops not up with sleep bits clear");
   aux_sleep_a: assert property (
      en_pin && aux_loop_sleep_bit && !main_loop_sleep_bit
      |=> !aux_loop_powered && main_loop_powered
   ) else $error("aux sleep touched the wrong loop");
   hiz_mode_a: assert property (
      presetn && en_pin && !wake_reg && !main_loop_sleep_bit
      |=> main_pump_active == !$past(main_pump_hiz_bit)
   ) else $error("pump state does not follow hiz bit");
   sync_hold_a: assert property (
      en_pin && !wake_reg && main_loop_sleep_bit
      && !main_pump_hiz_bit && main_pump_busy
      && main_state_reg != ST_SYNC_DOWN
      && main_state_reg != ST_ASYNC_DOWN
      |=> main_loop_powered && !main_pump_active
   ) else $error("sync power down did not wait for pump");
   async_now_a: assert property (
      en_pin && !wake_reg && main_loop_sleep_bit
      && main_pump_hiz_bit |=> main_state_reg == ST_ASYNC_DOWN
   ) else $error("asynchronous power down not immediate");
   auto_wake_a: assert property (
      wake_write_s ##1 wake_kept_s |=> main_pump_active
   ) else $error("feedback write did not wake main loop");
   lock_forced_a: assert property (
      main_down || !aux_up_reg
      |=> !(main_down && $past(main_down) && main_lock)
          && !(!aux_up_reg && $past(!aux_up_reg) && aux_lock)
   ) else $error("lock shown while powered down");
   combined_low_a: assert property (
      output_select_field == SEL_COMBINED
      && (!main_lock || !aux_lock) |=> !lock_out
   ) else $error("combined lock high with a loop unlocked");
   sticky_irq_a: assert property (
      |events |=> (irq_stat_reg & $past(events)) == $past(events)
   ) else $error("lock event lost from status");
endmodule
`default_nettype wire

// >>> pll_power_and_lock_detect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pll_power_and_lock_detect_tb;
   import pll_pwr_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, en_pin;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, irq, lock_out;
   logic        m_run, a_run, stuck, m_tick, a_tick, m_busy;
   logic [7:0]  m_err, a_err, m_err_ns, a_err_ns;
   logic        main_loop_powered, main_pump_active, aux_loop_powered;
   int          fails, total_checks;

   pll_power_and_lock_detect DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .en_pin(en_pin),
      .main_ref_tick(m_tick), .main_phase_err_ns(m_err_ns),
      .main_pump_busy(m_busy), .main_loop_powered(main_loop_powered),
      .main_pump_active(main_pump_active), .aux_ref_tick(a_tick),
      .aux_phase_err_ns(a_err_ns), .aux_loop_powered(aux_loop_powered),
      .lock_out(lock_out), .irq(irq));
   loop_model main_side (
      .pclk(pclk), .presetn(presetn), .run(m_run), .err_set(m_err),
      .stuck(stuck), .pump_on(main_pump_active), .tick(m_tick),
      .err(m_err_ns), .busy(m_busy));
   loop_model aux_side (
      .pclk(pclk), .presetn(presetn), .run(a_run), .err_set(a_err),
      .stuck(1'b0), .pump_on(1'b0), .tick(a_tick), .err(a_err_ns),
      .busy());

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // ---------------------------------------------------------------
   // bus and check helpers
   // ---------------------------------------------------------------
   task automatic conclude();
      if (fails == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      xfer(1'b1, a, d, q, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      repeat (2) @(posedge pclk);
      xfer(1'b0, a, 32'h0000_0000, q, e);
      chk(q, exp);
   endtask

   task automatic st(input logic [7:0] exp);
      rd_chk(STATUS_OFS, {24'h00_0000, exp});
   endtask

   task automatic bit_chk(input logic got, input logic exp);
      chk({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask

   // n consecutive ticks on one loop with a fixed phase error
   task automatic pulse(input logic aux, input logic [7:0] v, input int n);
      @(posedge pclk);
      a_run <= aux;
      m_run <= !aux;
      a_err <= v;
      m_err <= v;
      repeat (n) @(posedge pclk);
      a_run <= 1'b0;
      m_run <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic        e;
      int          n;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      en_pin = 1'b1;
      m_run = 1'b0;
      a_run = 1'b0;
      m_err = 8'h00;
      a_err = 8'h00;
      stuck = 1'b0;
      fails = 0;
      total_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(CTRL_OFS, CTRL_RESET);
      st(8'h4B);
      xfer(1'b0, 8'h18, 32'h0000_0000, q, e);
      bit_chk(e, 1'b1);
      chk(q, 32'h0000_0000);
      wr(CTRL_OFS, 32'h0000_0004);
      st(8'h49);
      bit_chk(main_pump_active, 1'b0);
      wr(CTRL_OFS, 32'h0000_0000);
      st(8'h4B);
      // sync power down must outlast the pump tail
      wr(CTRL_OFS, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      bit_chk(main_loop_powered, 1'b1);
      n = 0;
      while (main_loop_powered === 1'b1 && n < 30) begin
         @(posedge pclk);
         n++;
      end
      bit_chk(n >= 3 && n < 30 && m_busy === 1'b0, 1'b1);
      st(8'h48);
      wr(CTRL_OFS, 32'h0000_0000);
      stuck <= 1'b1;
      wr(CTRL_OFS, 32'h0000_0001);
      repeat (20) @(posedge pclk);
      st(8'h4D);
      wr(CTRL_OFS, 32'h0000_0005);
      st(8'h48);
      stuck <= 1'b0;
      wr(CTRL_OFS, 32'h0000_0002);
      st(8'h43);
      bit_chk(aux_loop_powered, 1'b0);
      for (n = 1; n < 4; n++) begin
         wr(CTRL_OFS, 32'h0000_0005 | 32'(n << 4));
         st(8'h48);
         wr(FEEDBACK_OFS, 32'h0000_1234);
         st(8'hCB);
      end
      rd_chk(FEEDBACK_OFS, 32'h0000_1234);
      en_pin <= 1'b0;
      st(8'h00);
      en_pin <= 1'b1;
      st(8'h48);
      // main lock with a miss at exactly the entry window
      wr(IRQ_EN_OFS, 32'h0000_0001);
      wr(CTRL_OFS, 32'h0000_0100);
      pulse(1'b0, 8'h05, 4);
      pulse(1'b0, 8'h0A, 1);
      pulse(1'b0, 8'h05, 4);
      st(8'h4B);
      bit_chk(irq, 1'b0);
      pulse(1'b0, 8'h05, 1);
      st(8'h5B);
      bit_chk(lock_out, 1'b1);
      bit_chk(irq, 1'b1);
      rd_chk(IRQ_STAT_OFS, 32'h0000_0001);
      wr(IRQ_CLR_OFS, 32'h0000_0001);
      rd_chk(IRQ_STAT_OFS, 32'h0000_0000);
      bit_chk(irq, 1'b0);
      pulse(1'b0, 8'h14, 1);
      st(8'h5B);
      pulse(1'b0, 8'h15, 1);
      st(8'h4B);
      bit_chk(lock_out, 1'b0);
      bit_chk(irq, 1'b0);
      rd_chk(IRQ_STAT_OFS, 32'h0000_0002);
      // aux windows, then the combined view
      wr(CTRL_OFS, 32'h0000_0200);
      pulse(1'b1, 8'h0E, 5);
      st(8'h6B);
      bit_chk(lock_out, 1'b1);
      pulse(1'b1, 8'h1E, 1);
      pulse(1'b0, 8'h05, 5);
      st(8'h7B);
      wr(CTRL_OFS, 32'h0000_0300);
      repeat (3) @(posedge pclk);
      bit_chk(lock_out, 1'b1);
      pulse(1'b1, 8'h1F, 1);
      st(8'h5B);
      bit_chk(lock_out, 1'b0);
      bit_chk(irq, 1'b1);
      wr(IRQ_EN_OFS, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      bit_chk(irq, 1'b0);
      wr(CTRL_OFS, 32'h0000_0305);
      st(8'h48);
      conclude();
   end

   // the tests need a few hundred cycles; this bound means a hang
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      conclude();
   end
endmodule
`default_nettype wire

// >>> pll_pwr_pkg.sv
`default_nettype none
// ---------------------------------------------------------------
// shared constants
// ---------------------------------------------------------------
package pll_pwr_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] FEEDBACK_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS   = 8'h08;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
   localparam logic [7:0] IRQ_CLR_OFS  = 8'h10;
   localparam logic [7:0] IRQ_EN_OFS   = 8'h14;
   // control register fields
   localparam int CTRL_MAIN_SLEEP = 0;
   localparam int CTRL_AUX_SLEEP  = 1;
   localparam int CTRL_MAIN_HIZ   = 2;
   localparam int CTRL_WAKE_LSB   = 4;
   localparam int CTRL_WAKE_W     = 2;
   localparam int CTRL_SEL_LSB    = 8;
   localparam int CTRL_SEL_W      = 4;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam logic [31:0] CTRL_WR_MASK = 32'h0000_0F37;
   // status register fields
   localparam int ST_MAIN_UP   = 0;
   localparam int ST_MAIN_PUMP = 1;
   localparam int ST_MAIN_WAIT = 2;
   localparam int ST_AUX_UP    = 3;
   localparam int ST_MAIN_LOCK = 4;
   localparam int ST_AUX_LOCK  = 5;
   localparam int ST_EN_PIN    = 6;
   localparam int ST_WAKE      = 7;
   // interrupt events
   localparam int IRQ_W         = 4;
   localparam int EV_MAIN_GAIN  = 0;
   localparam int EV_MAIN_LOSS  = 1;
   localparam int EV_AUX_GAIN   = 2;
   localparam int EV_AUX_LOSS   = 3;
   // output select codes
   localparam logic [3:0] SEL_LOW      = 4'h0;
   localparam logic [3:0] SEL_MAIN     = 4'h1;
   localparam logic [3:0] SEL_AUX      = 4'h2;
   localparam logic [3:0] SEL_COMBINED = 4'h3;
   // lock windows in ns and qualifying count
   localparam int LD_ERR_W        = 8;
   localparam int LD_MAIN_ENTER_NS = 10;
   localparam int LD_MAIN_EXIT_NS  = 20;
   localparam int LD_AUX_ENTER_NS  = 15;
   localparam int LD_AUX_EXIT_NS   = 30;
   localparam int LD_COUNT         = 5;
   localparam int FB_W             = 16;
   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_HIZ,
      ST_SYNC_WAIT,
      ST_SYNC_DOWN,
      ST_ASYNC_DOWN
   } loop_state_e;
endpackage
`default_nettype wire
